// >>> design/pgs_regs.svh
`ifndef PGS_REGS_SVH
`define PGS_REGS_SVH

// register byte offsets
`define PGS_OFF_STATUS   8'h00
`define PGS_OFF_PCIL     8'h04
`define PGS_OFF_DCA      8'h08
`define PGS_OFF_PER      8'h0c
`define PGS_OFF_DUTY     8'h10
`define PGS_OFF_CTRL     8'h14
`define PGS_OFF_CAPT     8'h18

// status bit positions
`define PGS_ST_CAP       5
`define PGS_ST_PEND      4
`define PGS_ST_REQ       3
`define PGS_ST_PUSH_PULL_PHASE     2
`define PGS_ST_HALF      1
`define PGS_ST_CYCLE_ACTIVE_FLAG      0

// control bit positions
`define PGS_CTRL_ALT     0

// source select field and codes
`define PGS_PSS_MSB      4
`define PGS_RSV_LO       5'h04
`define PGS_RSV_HI       5'h07

// reset values
`define PGS_RST_WORD     16'h0000
`define PGS_RST_ADJ      8'h00
`define PGS_RST_SEL      5'h00

// smallest sensible period for software
`define PGS_PER_MIN      16'h0010

`endif

// >>> design/pgs_pkg.sv
`default_nettype none
package pgs_pkg;
    typedef logic [15:0] pgs_word_t;
    typedef logic [7:0]  pgs_adj_t;
    typedef logic [4:0]  pgs_sel_t;
    typedef enum logic [2:0] {
        PGS_R_STATUS,
        PGS_R_PCIL,
        PGS_R_DCA,
        PGS_R_PER,
        PGS_R_DUTY,
        PGS_R_CTRL,
        PGS_R_CAPT,
        PGS_R_NONE
    } pgs_reg_t;
endpackage
`default_nettype wire

// >>> design/pgs_prot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pgs_prot_if;
    pgs_pkg::pgs_sel_t  sel;
    logic               use_alt;
    logic               alt_src;
    logic               active;
    pgs_pkg::pgs_word_t duty;
    pgs_pkg::pgs_adj_t  adj;
    pgs_pkg::pgs_word_t eff;
    modport ctl (output sel, output use_alt, output alt_src,
                 output duty, output adj, input active, input eff);
    modport mux (input sel, input use_alt, input alt_src,
                 output active);
    modport adj_p (input active, input duty, input adj, output eff);
endinterface
`default_nettype wire

// >>> design/pgs_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgs_regs.svh"
module pgs_src_mux (
    pgs_prot_if.mux          pif,
    input  wire logic [31:0] src_vec
);
    function automatic logic is_reserved(input logic [4:0] code);
        is_reserved = (code >= `PGS_RSV_LO) && (code <= `PGS_RSV_HI);
    endfunction

    logic [31:0] gated;
    logic        picked;

    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_gate
            assign gated[i] = src_vec[i] & ~is_reserved(5'(i));
        end
    endgenerate

    assign picked = gated[pif.sel];
    assign pif.active = pif.use_alt ? pif.alt_src : picked;
endmodule
`default_nettype wire

// >>> design/pgs_duty_adj.sv
`timescale 1ns/1ps
`default_nettype none
module pgs_duty_adj (
    input  wire logic pclk,
    input  wire logic presetn,
    pgs_prot_if.adj_p pif
);
    logic [16:0]        sum;
    pgs_pkg::pgs_word_t eff_r;

    // saturating so a large adjust cannot wrap to a tiny duty
    assign sum = {1'b0, pif.duty} + {9'h000, pif.adj};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_r <= 16'h0000;
        end else if (pif.active && pif.adj != 8'h00) begin
            eff_r <= sum[16] ? 16'hffff : sum[15:0];
        end else begin
            eff_r <= pif.duty;
        end
    end
    assign pif.eff = eff_r;

    adj_sum_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pif.active && pif.adj != 8'h00 && !sum[16])
        |=> eff_r == $past(pif.duty) + 16'($past(pif.adj)))
        else $error("adjusted duty wrong");
    adj_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!pif.active || pif.adj == 8'h00) |=> eff_r == $past(pif.duty))
        else $error("duty changed without adjust");
    adj_on_c: cover property (@(posedge pclk) disable iff (!presetn)
        pif.active && pif.adj != 8'h00);
endmodule
`default_nettype wire

// >>> design/pgs_top.sv
// Operation
// - capture sets status bit five
// - software capture request; flag blocks further
// - bit four shows pending update
// - bit three requests update, reads zero
// - bit two: push-pull second cycle
// - bit one: centre-aligned second half
// - bit zero: cycle in progress
// - code zero fixed; one to three shared, combo; four to seven reserved
// - codes eight up: inputs, pins, events
// - top codes: comparators, logic cell
// - active input adds adjust to duty
// - zero adjust disables; upper bits zero
// - compare-select bit picks gating input
`timescale 1ns/1ps
`default_nettype none
`include "pgs_regs.svh"
module pgs_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              capture_cycle_active_flag,
    input  wire logic [15:0]       time_base,
    input  wire logic              cycle_running,
    input  wire logic              push_pull_mode,
    input  wire logic              push_pull_second,
    input  wire logic              centre_mode,
    input  wire logic              centre_second,
    input  wire logic              update_applied,
    input  wire logic              shared_protect_mux,
    input  wire logic              combo_cycle_active_flag_a,
    input  wire logic              combo_cycle_active_flag_b,
    input  wire logic [10:0]       remap_pci,
    input  wire logic [3:0]        pin_pci,
    input  wire logic [3:0]        slave_evt,
    input  wire logic              master_cmp1,
    input  wire logic [2:0]        slave_cmp,
    input  wire logic              master_clc1,
    input  wire logic              alt_protect,
    output logic [15:0]            duty_effective,
    output logic [15:0]            period_value,
    output logic [15:0]            captured_time_base,
    output logic                   protect_active,
    output logic                   capture_flag,
    output logic                   update_pending
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    function automatic pgs_pkg::pgs_reg_t decode(
        input logic [ADDR_W-1:0] a);
        logic [7:0] lo;
        lo = 8'(a);
        decode = pgs_pkg::PGS_R_NONE;
        if (a == ADDR_W'(lo)) begin
            case (lo)
                `PGS_OFF_STATUS: decode = pgs_pkg::PGS_R_STATUS;
                `PGS_OFF_PCIL:   decode = pgs_pkg::PGS_R_PCIL;
                `PGS_OFF_DCA:    decode = pgs_pkg::PGS_R_DCA;
                `PGS_OFF_PER:    decode = pgs_pkg::PGS_R_PER;
                `PGS_OFF_DUTY:   decode = pgs_pkg::PGS_R_DUTY;
                `PGS_OFF_CTRL:   decode = pgs_pkg::PGS_R_CTRL;
                `PGS_OFF_CAPT:   decode = pgs_pkg::PGS_R_CAPT;
                default:         decode = pgs_pkg::PGS_R_NONE;
            endcase
        end
    endfunction

    pgs_pkg::pgs_reg_t  sel_reg;
    logic               setup;
    logic               wr;
    logic               rd_setup;
    logic               sw_cap;
    logic               cap_clr;
    logic               cap_evt;
    logic               cap_allow;
    logic               blk;
    logic [31:0]        rd_nxt;
    logic [31:0]        prdata_r;
    logic [31:0]        src_vec;
    logic [5:0]         status_v;
    logic               cap_flag_r;
    logic               pend_r;
    logic               alt_r;
    pgs_pkg::pgs_word_t capt_r;
    pgs_pkg::pgs_word_t per_r;
    pgs_pkg::pgs_word_t duty_r;
    pgs_pkg::pgs_adj_t  adj_r;
    pgs_pkg::pgs_sel_t  sel_r;

    pgs_prot_if pif ();

    // zero wait states: the read word is latched in the setup cycle
    assign sel_reg  = decode(paddr);
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    assign rd_setup = setup & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & (sel_reg == pgs_pkg::PGS_R_NONE);

    assign sw_cap  = wr & (sel_reg == pgs_pkg::PGS_R_STATUS)
                   & pwdata[`PGS_ST_CAP];
    assign cap_clr = wr & (sel_reg == pgs_pkg::PGS_R_STATUS)
                   & ~pwdata[`PGS_ST_CAP];
    assign cap_evt = capture_cycle_active_flag | sw_cap;
    assign cap_allow = ~cap_flag_r | cap_clr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capt_r <= `PGS_RST_WORD;
        end else if (cap_evt && cap_allow) begin
            capt_r <= time_base;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_flag_r <= 1'b0;
        end else if (cap_evt && cap_allow) begin
            cap_flag_r <= 1'b1;
        end else if (cap_clr) begin
            cap_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 1'b0;
        end else if (wr && sel_reg == pgs_pkg::PGS_R_STATUS
                     && pwdata[`PGS_ST_REQ]) begin
            pend_r <= 1'b1;
        end else if (update_applied) begin
            pend_r <= 1'b0;
        end
    end

    assign blk = pend_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_r <= `PGS_RST_WORD;
        end else if (wr && !blk && sel_reg == pgs_pkg::PGS_R_DUTY) begin
            duty_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_r <= `PGS_RST_WORD;
        end else if (wr && !blk && sel_reg == pgs_pkg::PGS_R_PER) begin
            per_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adj_r <= `PGS_RST_ADJ;
        end else if (wr && !blk && sel_reg == pgs_pkg::PGS_R_DCA) begin
            adj_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= `PGS_RST_SEL;
        end else if (wr && sel_reg == pgs_pkg::PGS_R_PCIL) begin
            sel_r <= pwdata[`PGS_PSS_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_r <= 1'b0;
        end else if (wr && sel_reg == pgs_pkg::PGS_R_CTRL) begin
            alt_r <= pwdata[`PGS_CTRL_ALT];
        end
    end

    always_comb begin
        status_v = 6'h00;
        status_v[`PGS_ST_CAP]   = cap_flag_r;
        status_v[`PGS_ST_PEND]  = pend_r;
        status_v[`PGS_ST_REQ]   = 1'b0;
        status_v[`PGS_ST_PUSH_PULL_PHASE] = push_pull_mode & push_pull_second;
        status_v[`PGS_ST_HALF]  = centre_mode & centre_second;
        status_v[`PGS_ST_CYCLE_ACTIVE_FLAG]  = cycle_running;
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (sel_reg)
            pgs_pkg::PGS_R_STATUS: rd_nxt = {26'h0000000, status_v};
            pgs_pkg::PGS_R_PCIL:   rd_nxt = {27'h0000000, sel_r};
            pgs_pkg::PGS_R_DCA:    rd_nxt = {24'h000000, adj_r};
            pgs_pkg::PGS_R_PER:    rd_nxt = {16'h0000, per_r};
            pgs_pkg::PGS_R_DUTY:   rd_nxt = {16'h0000, duty_r};
            pgs_pkg::PGS_R_CTRL:   rd_nxt = {31'h00000000, alt_r};
            pgs_pkg::PGS_R_CAPT:   rd_nxt = {16'h0000, capt_r};
            default:               rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= rd_nxt;
        end
    end
    assign prdata = prdata_r;

    assign src_vec = {master_clc1, slave_cmp, master_cmp1, slave_evt,
                      pin_pci, remap_pci, 4'h0, combo_cycle_active_flag_b,
                      combo_cycle_active_flag_a, shared_protect_mux, 1'b0};

    assign pif.sel     = sel_r;
    assign pif.use_alt = alt_r;
    assign pif.alt_src = alt_protect;
    assign pif.duty    = duty_r;
    assign pif.adj     = adj_r;

    pgs_src_mux u_mux (
        .pif     (pif),
        .src_vec (src_vec)
    );

    pgs_duty_adj u_adj (
        .pclk    (pclk),
        .presetn (presetn),
        .pif     (pif)
    );

    assign duty_effective     = pif.eff;
    assign protect_active     = pif.active;
    assign period_value       = per_r;
    assign captured_time_base = capt_r;
    assign capture_flag       = cap_flag_r;
    assign update_pending     = pend_r;

    cap_store_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (capture_cycle_active_flag && !cap_flag_r)
        |=> cap_flag_r && capt_r == $past(time_base))
        else $error("capture not stored");
    cap_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cap_flag_r && !cap_clr) |=> cap_flag_r && $stable(capt_r))
        else $error("capture while flag set");
    upd_req_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && sel_reg == pgs_pkg::PGS_R_STATUS && pwdata[`PGS_ST_REQ])
        |=> pend_r)
        else $error("request did not set pending");
    req_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && sel_reg == pgs_pkg::PGS_R_STATUS)
        |=> !prdata_r[`PGS_ST_REQ]
            && prdata_r[`PGS_ST_PEND] == $past(pend_r))
        else $error("status read wrong");
    wr_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pend_r |=> $stable(per_r) && $stable(duty_r) && $stable(adj_r))
        else $error("data written while pending");
    push_pull_phase_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && sel_reg == pgs_pkg::PGS_R_STATUS)
        |=> prdata_r[`PGS_ST_PUSH_PULL_PHASE]
            == $past(push_pull_mode && push_pull_second)
            && prdata_r[`PGS_ST_HALF]
            == $past(centre_mode && centre_second))
        else $error("push_pull_phase or half bit wrong");
    dca_hi_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && sel_reg == pgs_pkg::PGS_R_DCA)
        |=> prdata_r[31:8] == 24'h000000)
        else $error("adjust upper bits set");
    rsv_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!alt_r && sel_r >= `PGS_RSV_LO && sel_r <= `PGS_RSV_HI)
        |-> !pif.active)
        else $error("reserved source not low");
    cycle_active_flag_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && sel_reg == pgs_pkg::PGS_R_STATUS)
        |=> prdata_r[`PGS_ST_CYCLE_ACTIVE_FLAG] == $past(cycle_running))
        else $error("trigger bit wrong");
    alt_pick_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        alt_r |-> pif.active == alt_protect)
        else $error("alternate input not used");
    cap_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cap_clr && !capture_cycle_active_flag) |=> !cap_flag_r)
        else $error("capture flag not cleared");

    sw_cap_c: cover property (@(posedge pclk) disable iff (!presetn)
        sw_cap && !cap_flag_r ##1 cap_flag_r);
    upd_c: cover property (@(posedge pclk) disable iff (!presetn)
        pend_r ##[1:20] update_applied);
    blk_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr && blk && sel_reg == pgs_pkg::PGS_R_PER);
    cap_blk_c: cover property (@(posedge pclk) disable iff (!presetn)
        capture_cycle_active_flag && cap_flag_r);
endmodule
`default_nettype wire

// >>> testbench/pgs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgs_far_model (
    input  wire logic [4:0]  pick,
    input  wire logic        level,
    output logic             shared_protect_mux,
    output logic             combo_cycle_active_flag_a,
    output logic             combo_cycle_active_flag_b,
    output logic [10:0]      remap_pci,
    output logic [3:0]       pin_pci,
    output logic [3:0]       slave_evt,
    output logic             master_cmp1,
    output logic [2:0]       slave_cmp,
    output logic             master_clc1
);
    logic [31:0] v;
    // one source per code
    // unpicked sources show the opposite level so a wrong pick shows up
    assign v = level ? (32'h1 << pick) : ~(32'h1 << pick);
    assign shared_protect_mux = v[1];
    assign combo_cycle_active_flag_a       = v[2];
    assign combo_cycle_active_flag_b       = v[3];
    assign remap_pci          = v[18:8];
    assign pin_pci            = v[22:19];
    assign slave_evt          = v[26:23];
    assign master_cmp1        = v[27];
    assign slave_cmp          = v[30:28];
    assign master_clc1        = v[31];
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgs_regs.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e, cap_cycle_active_flag, run, ppm, pps, cm, cs, upd_app, alt, lvl;
    logic [15:0] tb_v, duty_eff, per_val, capt;
    logic [4:0]  pick;
    logic        shm, cta, ctb, cmp1, clc1, act, capf, pend;
    logic [10:0] rmp;
    logic [3:0]  pins, sev;
    logic [2:0]  scmp;
    int          err_total, compares;

    pgs_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_cycle_active_flag(cap_cycle_active_flag),
        .time_base(tb_v), .cycle_running(run), .push_pull_mode(ppm),
        .push_pull_second(pps), .centre_mode(cm), .centre_second(cs),
        .update_applied(upd_app), .shared_protect_mux(shm),
        .combo_cycle_active_flag_a(cta), .combo_cycle_active_flag_b(ctb), .remap_pci(rmp),
        .pin_pci(pins), .slave_evt(sev), .master_cmp1(cmp1),
        .slave_cmp(scmp), .master_clc1(clc1), .alt_protect(alt),
        .duty_effective(duty_eff), .period_value(per_val),
        .captured_time_base(capt), .protect_active(act),
        .capture_flag(capf), .update_pending(pend));

    pgs_far_model far (.pick(pick), .level(lvl), .shared_protect_mux(shm),
        .combo_cycle_active_flag_a(cta), .combo_cycle_active_flag_b(ctb), .remap_pci(rmp),
        .pin_pci(pins), .slave_evt(sev), .master_cmp1(cmp1),
        .slave_cmp(scmp), .master_clc1(clc1));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done();
    end

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] y);
        compares++;
        if (y !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, x, y);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(nm, x, q);
    endtask

    task automatic eff(input logic l, input logic a, input logic [15:0] x);
        @(posedge pclk);
        lvl <= l;
        alt <= a;
        repeat (2) @(posedge pclk);
        #1 chk("duty_eff", {16'h0, x}, {16'h0, duty_eff});
    endtask

    logic [7:0] offs [7];
    initial begin
        offs = '{`PGS_OFF_STATUS, `PGS_OFF_PCIL, `PGS_OFF_DCA, `PGS_OFF_PER,
                 `PGS_OFF_DUTY, `PGS_OFF_CTRL, `PGS_OFF_CAPT};
        {psel, penable, pwrite, cap_cycle_active_flag, run, ppm, pps, cm, cs} = 9'h0;
        {upd_app, alt, lvl} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tb_v = 16'h0000;
        pick = 5'h00;
        err_total = 0;
        compares = 0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd("reset_val", offs[i], 32'h0);
        $display("test reset done");

        wr(`PGS_OFF_DCA, 32'hffff_1ff5);
        rd("dca", `PGS_OFF_DCA, 32'h0000_00f5);
        wr(`PGS_OFF_PER, 32'h0000_0010);
        rd("per", `PGS_OFF_PER, 32'h0000_0010);
        chk("per_out", 32'h10, {16'h0, per_val});
        wr(`PGS_OFF_PCIL, 32'h0000_001b);
        rd("pcil", `PGS_OFF_PCIL, 32'h0000_001b);
        rd("unmapped", 8'h1c, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        $display("test registers done");

        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            {run, ppm, pps, cm, cs} <= i[4:0];
            rd("status", `PGS_OFF_STATUS,
               {29'h0, i[3] & i[2], i[1] & i[0], i[4]});
        end
        @(posedge pclk);
        {run, ppm, pps, cm, cs} <= 5'h00;
        $display("test status done");

        wr(`PGS_OFF_DUTY, 32'h0000_1000);
        wr(`PGS_OFF_STATUS, 32'h0000_0008);
        rd("status_req", `PGS_OFF_STATUS, 32'h0000_0010);
        chk("pending", 32'h1, {31'h0, pend});
        wr(`PGS_OFF_DUTY, 32'h0000_2222);
        wr(`PGS_OFF_PER, 32'h0000_0040);
        wr(`PGS_OFF_DCA, 32'h0000_0007);
        rd("duty_lock", `PGS_OFF_DUTY, 32'h0000_1000);
        rd("per_lock", `PGS_OFF_PER, 32'h0000_0010);
        rd("dca_lock", `PGS_OFF_DCA, 32'h0000_00f5);
        @(posedge pclk);
        upd_app <= 1'b1;
        @(posedge pclk);
        upd_app <= 1'b0;
        rd("status_clr", `PGS_OFF_STATUS, 32'h0);
        wr(`PGS_OFF_DUTY, 32'h0000_2222);
        rd("duty_open", `PGS_OFF_DUTY, 32'h0000_2222);
        $display("test update done");

        @(posedge pclk);
        tb_v <= 16'h1234;
        cap_cycle_active_flag <= 1'b1;
        @(posedge pclk);
        cap_cycle_active_flag <= 1'b0;
        rd("cap_flag", `PGS_OFF_STATUS, 32'h0000_0020);
        rd("capt", `PGS_OFF_CAPT, 32'h0000_1234);
        @(posedge pclk);
        tb_v <= 16'h5678;
        cap_cycle_active_flag <= 1'b1;
        @(posedge pclk);
        cap_cycle_active_flag <= 1'b0;
        rd("capt_block", `PGS_OFF_CAPT, 32'h0000_1234);
        wr(`PGS_OFF_STATUS, 32'h0);
        rd("cap_clr", `PGS_OFF_STATUS, 32'h0);
        chk("capf", 32'h0, {31'h0, capf});
        @(posedge pclk);
        tb_v <= 16'habcd;
        wr(`PGS_OFF_STATUS, 32'h0000_0020);
        rd("sw_capt", `PGS_OFF_CAPT, 32'h0000_abcd);
        chk("capt_out", 32'h0000_abcd, {16'h0, capt});
        wr(`PGS_OFF_STATUS, 32'h0);
        $display("test capture done");

        wr(`PGS_OFF_CTRL, 32'h0);
        for (int c = 0; c < 32; c++) begin
            wr(`PGS_OFF_PCIL, {27'h0, c[4:0]});
            for (int l = 0; l < 2; l++) begin
                @(posedge pclk);
                pick <= c[4:0];
                lvl <= l[0];
                @(posedge pclk);
                #1 chk("active",
                       {31'h0, (c == 0 || (c >= 4 && c <= 7)) ? 1'b0 : l[0]},
                       {31'h0, act});
            end
        end
        $display("test sources done");

        wr(`PGS_OFF_DUTY, 32'h0000_1000);
        wr(`PGS_OFF_DCA, 32'h0000_0020);
        wr(`PGS_OFF_PCIL, 32'h0000_0002);
        @(posedge pclk);
        pick <= 5'h02;
        eff(1'b1, 1'b0, 16'h1020);
        eff(1'b0, 1'b0, 16'h1000);
        wr(`PGS_OFF_DCA, 32'h0);
        eff(1'b1, 1'b0, 16'h1000);
        wr(`PGS_OFF_DCA, 32'h0000_0020);
        wr(`PGS_OFF_DUTY, 32'h0000_fff0);
        eff(1'b1, 1'b0, 16'hffff);
        wr(`PGS_OFF_DUTY, 32'h0000_1000);
        wr(`PGS_OFF_CTRL, 32'h0000_0001);
        eff(1'b0, 1'b1, 16'h1020);
        eff(1'b1, 1'b0, 16'h1000);
        $display("test adjust done");
        test_done();
    end
endmodule
`default_nettype wire
